// file: design/amc_mode_ctrl.sv
// Mode control for a stereo amplifier: output configuration, input
// selection, shutdown and the tone takeover path.
// Assumes all control inputs are static levels synchronous to SYS_CLK.
`timescale 1ns/1ps
// Operation
// - Select low keeps negative followers on and both channels bridged.
// - Select high turns negative outputs off; channels drive single-ended.
// - Active tone deselects line and headphone pairs; bridged from tone.
// - When tone ends, the previous mode returns and the current host volume is applied.
// - Tone during shutdown wakes the amplifier, then returns to shutdown.
// - With detect enable low, switch to tone mode on valid tone.
// - Tone is valid only after at least eight rising edges.
// - Line pair is used when bridged, headphone pair when single-ended.
// - Shutdown low mutes outputs and enters low current, any select.
module amc_mode_ctrl import amc_pkg::*; #(
   parameter int MIN_EDGES = TONE_MIN_EDGES,
   parameter int TIMEOUT_CYC = TONE_TIMEOUT_CYC
) (
   input wire logic SYS_CLK, // System clock, 125 MHz.
   input wire logic NRST, // Asynchronous reset, active low.
   input wire logic OUTPUT_CONFIG_SELECT, // Low bridged, high single-ended.
   input wire logic SHUTDOWN_N, // Low requests shutdown.
   input wire logic TONE_INPUT, // Tone input level.
   input wire logic TONE_DETECT_ENABLE_N, // Low enables auto detection.
   input wire logic [VOL_W-1:0] VOLUME, // Host volume setting.
   output logic LEFT_POSITIVE_OUTPUT_EN, // Left positive amp enabled.
   output logic RIGHT_POSITIVE_OUTPUT_EN, // Right positive amp enabled.
   output logic LEFT_NEGATIVE_OUTPUT_EN, // Left negative follower on.
   output logic RIGHT_NEGATIVE_OUTPUT_EN, // Right negative follower on.
   output logic LINE_INPUT_PAIR_SEL, // Line pair selected.
   output logic HEADPHONE_INPUT_PAIR_SEL, // Headphone pair selected.
   output logic TONE_SEL, // Tone drives the outputs.
   output logic BRIDGED_MODE, // Outputs run bridged.
   output logic MUTE, // Outputs muted.
   output logic LOW_POWER, // Low-current state.
   output logic [GAIN_W-1:0] TONE_GAIN_OUT, // Fixed tone gain code.
   output logic [VOL_W-1:0] VOLUME_OUT // Applied volume.
);
   logic rst_meta, rst_n;
   logic tone_valid, tone_act;
   logic next_lpos, next_rpos, next_lneg, next_rneg;
   logic next_line, next_hp, next_tone, next_btl, next_mute, next_lowp;
   logic [GAIN_W-1:0] next_gain;
   logic [VOL_W-1:0] next_vol, saved_vol, next_saved_vol;

   // Reset release through two flops; assertion stays asynchronous.
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   amc_tone_detect #(
      .MIN_EDGES(MIN_EDGES),
      .TIMEOUT_CYC(TIMEOUT_CYC)
   ) u_detect (
      .clk(SYS_CLK),
      .rst_n(rst_n),
      .tone_in(TONE_INPUT),
      .valid(tone_valid)
   );

   // Takeover only while detection is enabled by the low level.
   assign tone_act = tone_valid & ~TONE_DETECT_ENABLE_N;

   // Volume held while the tone owns the outputs. The host value is
   // frozen at takeover so a change during the tone is not applied until
   // the tone ends; that keeps the restored setting the one in force.
   always_comb begin
      next_saved_vol = saved_vol;
      if (!TONE_SEL) begin
         next_saved_vol = VOLUME;
      end
   end

   // Output decode: tone first, then shutdown, then the select pin.
   always_comb begin
      next_gain = TONE_GAIN;
      next_vol = VOLUME;
      next_tone = 1'b0;
      next_mute = 1'b0;
      next_lowp = 1'b0;
      if (tone_act) begin
         // Tone wakes even from shutdown and forces bridged output.
         next_tone = 1'b1;
         next_btl = 1'b1;
         next_line = 1'b0;
         next_hp = 1'b0;
         next_lpos = 1'b1;
         next_rpos = 1'b1;
         next_lneg = 1'b1;
         next_rneg = 1'b1;
         next_vol = TONE_SEL ? saved_vol : VOLUME;
      end else if (!SHUTDOWN_N) begin
         // Select pin is a don't-care while shut down.
         next_mute = 1'b1;
         next_lowp = 1'b1;
         next_btl = 1'b0;
         next_line = 1'b0;
         next_hp = 1'b0;
         next_lpos = 1'b0;
         next_rpos = 1'b0;
         next_lneg = 1'b0;
         next_rneg = 1'b0;
         next_vol = TONE_SEL ? saved_vol : VOLUME;
      end else begin
         next_btl = ~OUTPUT_CONFIG_SELECT;
         next_line = ~OUTPUT_CONFIG_SELECT;
         next_hp = OUTPUT_CONFIG_SELECT;
         next_lpos = 1'b1;
         next_rpos = 1'b1;
         next_lneg = ~OUTPUT_CONFIG_SELECT;
         next_rneg = ~OUTPUT_CONFIG_SELECT;
         next_vol = TONE_SEL ? saved_vol : VOLUME;
      end
   end

   // All outputs registered; reset state is muted and shut down.
   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         LEFT_POSITIVE_OUTPUT_EN <= 1'b0;
         RIGHT_POSITIVE_OUTPUT_EN <= 1'b0;
         LEFT_NEGATIVE_OUTPUT_EN <= 1'b0;
         RIGHT_NEGATIVE_OUTPUT_EN <= 1'b0;
         LINE_INPUT_PAIR_SEL <= 1'b0;
         HEADPHONE_INPUT_PAIR_SEL <= 1'b0;
         TONE_SEL <= 1'b0;
         BRIDGED_MODE <= 1'b0;
         MUTE <= 1'b1;
         LOW_POWER <= 1'b1;
         TONE_GAIN_OUT <= TONE_GAIN;
         VOLUME_OUT <= VOL_RESET;
         saved_vol <= VOL_RESET;
      end else begin
         LEFT_POSITIVE_OUTPUT_EN <= next_lpos;
         RIGHT_POSITIVE_OUTPUT_EN <= next_rpos;
         LEFT_NEGATIVE_OUTPUT_EN <= next_lneg;
         RIGHT_NEGATIVE_OUTPUT_EN <= next_rneg;
         LINE_INPUT_PAIR_SEL <= next_line;
         HEADPHONE_INPUT_PAIR_SEL <= next_hp;
         TONE_SEL <= next_tone;
         BRIDGED_MODE <= next_btl;
         MUTE <= next_mute;
         LOW_POWER <= next_lowp;
         TONE_GAIN_OUT <= next_gain;
         VOLUME_OUT <= next_vol;
         saved_vol <= next_saved_vol;
      end
   end

   // Bridged normal operation keeps negative followers on.
   bridged_neg_a: assert property (
      @(posedge SYS_CLK) disable iff (!rst_n)
      (!OUTPUT_CONFIG_SELECT && SHUTDOWN_N && !tone_act) |=>
      (LEFT_NEGATIVE_OUTPUT_EN && RIGHT_NEGATIVE_OUTPUT_EN
       && BRIDGED_MODE))
      else $error("bridged mode without negative followers");
   // Single-ended operation turns negative outputs off.
   se_neg_off_a: assert property (
      @(posedge SYS_CLK) disable iff (!rst_n)
      (OUTPUT_CONFIG_SELECT && SHUTDOWN_N && !tone_act) |=>
      (!LEFT_NEGATIVE_OUTPUT_EN && !RIGHT_NEGATIVE_OUTPUT_EN
       && LEFT_POSITIVE_OUTPUT_EN && !BRIDGED_MODE))
      else $error("single-ended mode with negative outputs driving");
   // Tone takeover deselects both pairs and runs bridged.
   tone_take_a: assert property (
      @(posedge SYS_CLK) disable iff (!rst_n)
      tone_act |=> (TONE_SEL && BRIDGED_MODE && !LINE_INPUT_PAIR_SEL
       && !HEADPHONE_INPUT_PAIR_SEL && !MUTE))
      else $error("tone active without takeover");
   // Tone gain never moves.
   tone_gain_a: assert property (
      @(posedge SYS_CLK) disable iff (!rst_n)
      TONE_GAIN_OUT == TONE_GAIN)
      else $error("tone gain changed");
   // Host volume changes are held off while the tone owns the outputs.
   tone_vol_a: assert property (
      @(posedge SYS_CLK) disable iff (!rst_n)
      (TONE_SEL && tone_act) |=> $stable(VOLUME_OUT))
      else $error("volume moved during tone");
   // Volume in the first cycle after the tone equals the one saved before it.
   vol_restore_a: assert property (
      @(posedge SYS_CLK) disable iff (!rst_n)
      (TONE_SEL && !tone_act && SHUTDOWN_N) |=>
      VOLUME_OUT == $past(saved_vol))
      else $error("volume not restored after tone");
   // Single-ended operation comes back on the headphone pair.
   se_restore_a: assert property (
      @(posedge SYS_CLK) disable iff (!rst_n)
      (TONE_SEL && !tone_act && SHUTDOWN_N && OUTPUT_CONFIG_SELECT) |=>
      (!TONE_SEL && HEADPHONE_INPUT_PAIR_SEL && !BRIDGED_MODE))
      else $error("mode not restored after tone");
   // A tone during shutdown wakes the amplifier fully.
   tone_wake_a: assert property (
      @(posedge SYS_CLK) disable iff (!rst_n)
      (!SHUTDOWN_N && tone_act) |=> (!MUTE && !LOW_POWER
       && LEFT_NEGATIVE_OUTPUT_EN && RIGHT_NEGATIVE_OUTPUT_EN))
      else $error("tone did not wake the amplifier");
   // Shutdown during a tone returns to mute when the tone ends.
   shut_return_a: assert property (
      @(posedge SYS_CLK) disable iff (!rst_n)
      (!SHUTDOWN_N && TONE_SEL && !tone_act) |=> (MUTE && LOW_POWER))
      else $error("no return to shutdown after tone");
   // Detect enable high blocks takeover.
   detect_gate_a: assert property (
      @(posedge SYS_CLK) disable iff (!rst_n)
      TONE_DETECT_ENABLE_N |=> !TONE_SEL)
      else $error("takeover with detection disabled");
   // Input pair follows the mode.
   mux_sel_a: assert property (
      @(posedge SYS_CLK) disable iff (!rst_n)
      (SHUTDOWN_N && !tone_act) |=> (LINE_INPUT_PAIR_SEL == BRIDGED_MODE
       && HEADPHONE_INPUT_PAIR_SEL == !BRIDGED_MODE))
      else $error("input pair does not match mode");
   // Shutdown mutes regardless of the select pin.
   shut_mute_a: assert property (
      @(posedge SYS_CLK) disable iff (!rst_n)
      (!SHUTDOWN_N && !tone_act) |=> (MUTE && LOW_POWER
       && !LEFT_POSITIVE_OUTPUT_EN && !RIGHT_POSITIVE_OUTPUT_EN))
      else $error("shutdown did not mute");
endmodule : amc_mode_ctrl

// file: design/amc_tone_detect.sv
// Tone presence detector: counts rising edges and times out on silence.
// Assumes tone_in is already synchronous to clk; reset is synchronised.
`timescale 1ns/1ps
module amc_tone_detect import amc_pkg::*; #(
   parameter int MIN_EDGES = TONE_MIN_EDGES,
   parameter int TIMEOUT_CYC = TONE_TIMEOUT_CYC
) (
   input wire logic clk, // System clock.
   input wire logic rst_n, // Synchronised reset, active low.
   input wire logic tone_in, // Tone input level.
   output logic valid // Tone currently detected.
);
   localparam int EW = $clog2(MIN_EDGES + 1);
   localparam int TW = $clog2(TIMEOUT_CYC + 1);
   logic prev, next_prev, next_valid;
   logic [EW-1:0] edges, next_edges;
   logic [TW-1:0] idle, next_idle;
   logic rise;

   // Edge count rises per rising edge up to MIN_EDGES; a long gap clears the count, the idle timer and valid.
   always_comb begin
      rise = tone_in & ~prev;
      next_prev = tone_in;
      next_edges = edges;
      next_idle = idle;
      next_valid = valid;
      if (rise) begin
         next_idle = '0;
         if (edges < EW'(MIN_EDGES)) begin
            next_edges = edges + EW'(1);
         end
         if (edges >= EW'(MIN_EDGES - 1)) begin
            next_valid = 1'b1;
         end
      end else if (idle >= TW'(TIMEOUT_CYC - 1)) begin
         next_edges = '0;
         next_valid = 1'b0;
         next_idle = '0;
      end else begin
         next_idle = idle + TW'(1);
      end
   end

   // Registers only.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev <= 1'b0;
         edges <= '0;
         idle <= '0;
         valid <= 1'b0;
      end else begin
         prev <= next_prev;
         edges <= next_edges;
         idle <= next_idle;
         valid <= next_valid;
      end
   end

   // Valid may only rise on an edge that completes the minimum count.
   valid_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(valid) |-> $past(edges) == EW'(MIN_EDGES - 1))
      else $error("tone valid rose before minimum edge count");
   // A lost tone leaves the edge count cleared.
   lost_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(valid) |-> edges == '0 && !$past(rise))
      else $error("tone lost without clearing edge count");
endmodule : amc_tone_detect

// file: pkg/amc_pkg.sv
// Constants shared by the amplifier mode and tone control logic.
// Assumes a single 125 MHz system clock; all inputs are synchronous.
package amc_pkg;
   // System clock period in nanoseconds.
   localparam int CLK_PERIOD_NS = 8;
   // Least number of rising edges before a tone counts as valid.
   localparam int TONE_MIN_EDGES = 8;
   // Gap without a rising edge after which the tone is lost, in us.
   localparam int TONE_TIMEOUT_US = 1000;
   // Timeout in clock cycles, rounded down as a longest time.
   localparam int TONE_TIMEOUT_CYC = (TONE_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
   // Width of the fixed tone gain code.
   localparam int GAIN_W = 8;
   // Fixed tone path gain code, 0.3 V/V scaled by 256 and truncated.
   localparam logic [7:0] TONE_GAIN = 8'h4C;
   // Width of the volume setting.
   localparam int VOL_W = 5;
   // Volume after reset: lowest step.
   localparam logic [4:0] VOL_RESET = 5'h00;
   // Source selection codes.
   typedef enum logic [1:0] {AMC_SRC_NONE, AMC_SRC_LINE, AMC_SRC_HP,
                             AMC_SRC_TONE} amc_src_t;
endpackage : amc_pkg

// file: tb/amc_host_model.sv
// Host logic and headphone jack model: mode levels and the tone line.
// Assumes the bench calls its tasks; levels move 1 ns after clk rises.
`timescale 1ns/1ps
module amc_host_model (
   input wire logic clk, // System clock.
   output logic select, // Jack sense, high when a plug is in.
   output logic shutdown_n, // Low asks for shutdown.
   output logic tone, // Tone square wave.
   output logic detect_en_n // Low enables tone takeover.
);
   // Every level is defined from time zero; a floating shutdown is unsafe.
   initial begin
      select = 1'b0;
      shutdown_n = 1'b1;
      tone = 1'b0;
      detect_en_n = 1'b0;
   end

   // Levels change together, just after an edge, and then stay put.
   task automatic set_levels(input logic sel, input logic sd_n,
                             input logic den_n);
      @(posedge clk);
      #1;
      select = sel;
      shutdown_n = sd_n;
      detect_en_n = den_n;
   endtask : set_levels

   // Period of four cycles, since edges need two cycles of spacing.
   task automatic burst(input int n);
      for (int i = 0; i < n; i++) begin
         repeat (2) @(posedge clk);
         #1;
         tone = 1'b1;
         repeat (2) @(posedge clk);
         #1;
         tone = 1'b0;
      end
   endtask : burst
endmodule : amc_host_model

// file: tb/amp_mode_and_beep_control_bench.sv
// Self-checking bench for the mode control and tone takeover logic.
// Assumes the host model drives the levels; timeout shortened to TMO.
`timescale 1ns/1ps
module amp_mode_and_beep_control_bench import amc_pkg::*;;
   localparam int TMO = 50;
   localparam logic [9:0] M_BTL = 10'h1F4;
   localparam logic [9:0] M_SE = 10'h188;
   localparam logic [9:0] M_TONE = 10'h3E4;
   logic SYS_CLK = 1'b0;
   logic NRST = 1'b0;
   logic [VOL_W-1:0] VOLUME = 5'h0A;
   logic sel, sd_n, tone, den_n, tsel;
   wire [8:0] m;
   logic [GAIN_W-1:0] gain;
   logic [VOL_W-1:0] vol_o;
   int num_errors = 0;
   int n_checks = 0;
   int cnt;
   // Tone select on top, then enables, pair selects, bridged, mute, power.
   wire [9:0] mode = {tsel, m};

   // Half period of 4 ns gives 125 MHz.
   always #4 SYS_CLK = ~SYS_CLK;

   amc_host_model host (.clk(SYS_CLK), .select(sel), .shutdown_n(sd_n),
      .tone(tone), .detect_en_n(den_n));

   amc_mode_ctrl #(.MIN_EDGES(8), .TIMEOUT_CYC(TMO)) DUT (
      .SYS_CLK(SYS_CLK), .NRST(NRST), .OUTPUT_CONFIG_SELECT(sel),
      .SHUTDOWN_N(sd_n), .TONE_INPUT(tone), .TONE_DETECT_ENABLE_N(den_n),
      .VOLUME(VOLUME), .LEFT_POSITIVE_OUTPUT_EN(m[8]),
      .RIGHT_POSITIVE_OUTPUT_EN(m[7]), .LEFT_NEGATIVE_OUTPUT_EN(m[6]),
      .RIGHT_NEGATIVE_OUTPUT_EN(m[5]), .LINE_INPUT_PAIR_SEL(m[4]),
      .HEADPHONE_INPUT_PAIR_SEL(m[3]), .TONE_SEL(tsel),
      .BRIDGED_MODE(m[2]), .MUTE(m[1]), .LOW_POWER(m[0]),
      .TONE_GAIN_OUT(gain), .VOLUME_OUT(vol_o));

   task automatic summarize();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize

   task automatic chk(input logic [9:0] got, input logic [9:0] exp,
                      input string what);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got,
                  exp);
      end
   endtask : chk

   task automatic step(input int n);
      repeat (n) @(posedge SYS_CLK);
      #1;
   endtask : step

   // Bounded wait on tone select; the count shows when the tone was lost.
   task automatic wait_sel(input logic lvl, input int lim, output int c);
      c = 0;
      while (tsel !== lvl) begin
         step(1);
         c++;
         if (c > lim) begin
            chk(10'h000, 10'h001, "tone select wait");
            summarize();
         end
      end
   endtask : wait_sel

   // Mode table, with shutdown winning over either select level.
   task automatic t_modes();
      host.set_levels(1'b0, 1'b1, 1'b1);
      step(2);
      chk(mode, M_BTL, "bridged line mode");
      host.set_levels(1'b1, 1'b1, 1'b1);
      step(2);
      chk(mode, M_SE, "single-ended hp mode");
      for (int s = 1; s >= 0; s--) begin
         host.set_levels(s[0], 1'b0, 1'b1);
         step(2);
         chk(mode, 10'h003, "shutdown mute");
      end
   endtask : t_modes

   // Seven edges are too few, and silence must clear the partial count.
   task automatic t_count();
      host.set_levels(1'b0, 1'b1, 1'b0);
      host.burst(7);
      chk(mode, M_BTL, "seven edges ignored");
      step(TMO + 5);
      host.burst(7);
      chk(mode, M_BTL, "count cleared on loss");
      step(TMO + 5);
   endtask : t_count

   // Takeover, frozen volume, loss after the timeout, then restore.
   task automatic t_tone(input logic s, input logic sd, input logic [9:0] ex,
                         input logic [9:0] mask);
      host.set_levels(s, sd, 1'b0);
      VOLUME = 5'h0A;
      host.burst(10);
      chk(mode, M_TONE, "tone takeover");
      chk(gain, TONE_GAIN, "fixed tone gain");
      VOLUME = 5'h1F;
      step(2);
      chk(vol_o, 10'h00A, "volume frozen in tone");
      wait_sel(1'b0, TMO + 10, cnt);
      chk(cnt > TMO - 12, 10'h001, "tone held until timeout");
      step(2);
      chk(mode & mask, ex, "mode restored");
      chk(vol_o, 10'h01F, "volume after tone");
   endtask : t_tone

   // With detection disabled a full tone must not take over.
   task automatic t_disabled();
      host.set_levels(1'b0, 1'b1, 1'b1);
      host.burst(10);
      chk(mode, M_BTL, "tone ignored when disabled");
      step(TMO + 5);
   endtask : t_disabled

   // Reset for eight cycles, let the internal reset leave, then scenarios.
   initial begin
      repeat (8) @(posedge SYS_CLK);
      #1;
      NRST = 1'b1;
      step(3);
      t_modes();
      t_count();
      t_tone(1'b1, 1'b1, M_SE, 10'h3FF);
      t_tone(1'b0, 1'b0, 10'h003, 10'h3FF);
      t_disabled();
      summarize();
   end
endmodule : amp_mode_and_beep_control_bench
